// ==== design/rgb_in_host.sv ====
/*
  Host end: generates pixel clock, syncs and data at nominal geometry.
  Assumes i_mclk at 125 MHz; pixel clock is a divided copy driven out.
*/
`timescale 1ns/1ps
`default_nettype none
module rgb_in_host (
  input  wire logic        i_mclk,
  input  wire logic        i_arst_n,
  rgb_in_if.host           link,
  input  wire logic        i_parallel,
  input  wire logic        i_config_busy,
  input  wire logic [23:0] i_pixel,
  output logic             o_pixel_taken,
  output logic             o_running
);
  import rgb_in_pkg::*;

  typedef struct packed {
    logic [3:0]  div;
    logic        pclk;
    logic        mode;
    logic [11:0] hcnt;
    logic [8:0]  vcnt;
    logic [13:0] rst_cnt;
    logic        rst_done;
    logic [7:0]  csb_cnt;
    logic [1:0]  byte_ix;
    logic [7:0]  r_d;
    logic [7:0]  g_d;
    logic [7:0]  b_d;
    logic        hs;
    logic        vs;
    logic        taken;
  } host_t;

  host_t r;
  host_t next_r;
  logic  [3:0]  div_half;
  logic  [11:0] line_len;
  logic  [11:0] act_lo;
  logic  [11:0] act_hi;
  logic         act;
  logic         pfall;

  always_comb begin
    next_r = r;
    next_r.taken = 1'b0;
    // 6 + 6 mclk, 10.4 MHz
    // 2 high + 3 low mclk, 25 MHz at 40 percent duty
    div_half = r.mode ? 4'h5 : (r.pclk ? 4'h1 : 4'h2);
    line_len = r.mode ? 12'(PAR_LINE_NOM) : 12'(SER_LINE);
    act_lo = r.mode ? 12'(PAR_HBP_NOM) : 12'(SER_HBP);
    act_hi = r.mode ? 12'(PAR_HBP_NOM + PAR_ACTIVE) : 12'(SER_HBP + SER_ACTIVE);
    act = (r.hcnt >= act_lo) && (r.hcnt < act_hi)
          && (r.vcnt >= 9'(VBP_NOM)) && (r.vcnt < 9'(VBP_NOM + ACTIVE_LINES));
    pfall = 1'b0;
    if (!r.rst_done) begin
      next_r.rst_cnt = r.rst_cnt + 14'h0001;
      if (r.rst_cnt == 14'(RESET_CYC)) begin
        next_r.rst_done = 1'b1;
        next_r.mode = i_parallel;
      end
    end else if (i_config_busy) begin
      next_r.csb_cnt = 8'h00;
    end else if (r.csb_cnt != 8'(CSB_GAP_CYC)) begin
      next_r.csb_cnt = r.csb_cnt + 8'h01;
    end else if (r.div == div_half) begin
      next_r.div = 4'h0;
      next_r.pclk = ~r.pclk;
      pfall = r.pclk;
    end else begin
      next_r.div = r.div + 4'h1;
    end
    // Outputs change on falling pixel clock, panel samples on rising
    if (pfall) begin
      if (r.hcnt == line_len - 12'h001) begin
        next_r.hcnt = 12'h000;
        // 288 line frame, 8 line front porch
        next_r.vcnt = (r.vcnt == 9'(FRAME_NOM - 1)) ? 9'h000 : r.vcnt + 9'h001;
      end else begin
        next_r.hcnt = r.hcnt + 12'h001;
      end
      next_r.hs = (r.hcnt == line_len - 12'h001);
      next_r.vs = (next_r.vcnt == 9'h000);
      if (act) begin
        if (r.mode) begin
          {next_r.r_d, next_r.g_d, next_r.b_d} = i_pixel;
          next_r.taken = 1'b1;
        end else begin
          case (r.byte_ix)
            2'h0: next_r.r_d = i_pixel[23:16];
            2'h1: next_r.r_d = i_pixel[15:8];
            2'h2: next_r.r_d = i_pixel[7:0];
            default: next_r.r_d = 8'h00;
          endcase
          next_r.byte_ix = (r.byte_ix == 2'h2) ? 2'h0 : r.byte_ix + 2'h1;
          next_r.taken = (r.byte_ix == 2'h2);
        end
      end else begin
        next_r.byte_ix = 2'h0;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign link.pixel_clock = r.pclk;
  assign link.line_sync_n = ~r.hs;
  assign link.frame_sync_n = ~r.vs;
  assign link.parallel_sel = r.mode;
  assign link.red_data_bus = r.r_d;
  assign link.green_data = r.g_d;
  assign link.blue_data = r.b_d;
  assign link.global_reset_n = r.rst_done;
  assign link.config_chip_select_n = ~i_config_busy;
  assign o_pixel_taken = r.taken;
  assign o_running = r.rst_done;
endmodule // rgb_in_host
`default_nettype wire

// ==== design/rgb_in_if.sv ====
/*
  Carrier between the host display controller and the panel input port.
  Assumes the host drives pixel clock here and the panel clocks its link logic from it.
*/
`timescale 1ns/1ps
`default_nettype none
interface rgb_in_if;
  import rgb_in_pkg::*;
  logic       pixel_clock;
  logic       line_sync_n;
  logic       frame_sync_n;
  logic       parallel_sel;
  logic [7:0] red_data_bus;
  logic [7:0] green_data;
  logic [7:0] blue_data;
  logic       global_reset_n;
  logic       config_chip_select_n;
  modport host (
    output pixel_clock, line_sync_n, frame_sync_n, parallel_sel,
    output red_data_bus, green_data, blue_data, global_reset_n,
    output config_chip_select_n
  );
  modport panel (
    input pixel_clock, line_sync_n, frame_sync_n, parallel_sel,
    input red_data_bus, green_data, blue_data, global_reset_n,
    input config_chip_select_n
  );
endinterface
`default_nettype wire

// ==== design/rgb_in_panel.sv ====
/*
  Panel end of the pixel input port: counts line and frame geometry on the
  pixel clock, assembles pixels and times source, gate and common drive.
  Assumes the pixel clock runs all link-side logic; status reaches the
  system clock domain through two-flop synchronisers.
*/
// How it works
// - Host keeps parallel clock 5-12 MHz
// - Parallel line lasts 520 to 800 clocks
// - Take 480 active pixels per parallel line
// - Host gives parallel back porch 36-255; panel takes pixels from a fixed back porch of 40 (PAR_HBP_NOM)
// - Host gives parallel front porch 4-65
// - Show exactly 272 active lines per frame
// - First line after programmable 3-31 line delay
// - Host gives vertical front porch 2-97
// - Host keeps frame 277 to 400 lines
// - Host keeps serial clock 24-30 MHz
// - Serial line lasts exactly 1728 clocks
// - Take 1440 active serial bytes per line
// - Host gives serial back porch 120
// - Host gives serial front porch 168
// - Update source outputs 13 clocks after sync
// - Gate on 27 clocks after line sync
// - Previous gate off 3 clocks after sync
// - Toggle common polarity 12 clocks after sync
// - Host holds reset at least 10 us
`timescale 1ns/1ps
`default_nettype none
module rgb_in_panel (
  input  wire logic        i_mclk,
  input  wire logic        i_arst_n,
  rgb_in_if.panel          link,
  input  wire logic [4:0]  i_vertical_start_delay,
  output logic      [23:0] o_pixel,
  output logic             o_pixel_valid,
  output logic      [8:0]  o_line,
  output logic             o_source_load,
  output logic             o_gate_on,
  output logic             o_gate_off,
  output logic             o_common_electrode_drive,
  output logic             o_line_error,
  output logic             o_frame_done
);
  import rgb_in_pkg::*;

  typedef struct packed {
    logic        hs_d;
    logic        vs_d;
    logic        vs_seen;
    logic [11:0] hcnt;
    logic [8:0]  vcnt;
    logic [8:0]  act_line;
    logic [1:0]  byte_ix;
    logic [15:0] rg;
    logic [23:0] pix;
    logic        pix_v;
    logic        src;
    logic        gon;
    logic        goff;
    logic        common_electrode_drive;
    logic        line_err;
    logic        frame_tgl;
    logic        hs_seen;
    logic [4:0]  vdly_meta;
    logic [4:0]  vdly;
  } link_t;

  typedef struct packed {
    logic [1:0] err_sync;
    logic [2:0] done_sync;
  } sys_t;

  link_t r;
  link_t next_r;
  sys_t  s;
  sys_t  next_s;
  logic  rst_n;
  logic  in_line_act;
  logic  in_vact;
  logic  hs_fall;
  logic  vs_fall;
  logic [8:0] vstart;

  // Panel reset is the host reset pin combined with the system reset
  assign rst_n  = i_arst_n & link.global_reset_n;
  assign hs_fall = r.hs_d & ~link.line_sync_n;
  assign vs_fall = r.vs_d & ~link.frame_sync_n;
  // Static setting, two flops bring it onto the pixel clock
  assign vstart = {4'h0, r.vdly};

  always_comb begin
    next_r = r;
    next_r.hs_d = link.line_sync_n;
    next_r.vs_d = link.frame_sync_n;
    next_r.vdly_meta = i_vertical_start_delay;
    next_r.vdly = r.vdly_meta;
    next_r.pix_v = 1'b0;
    next_r.src = 1'b0;
    next_r.gon = 1'b0;
    next_r.goff = 1'b0;
    in_vact = r.vs_seen && (r.vcnt >= vstart)
              && (r.vcnt < vstart + 9'(ACTIVE_LINES));
    if (link.parallel_sel) begin
      in_line_act = (r.hcnt >= 12'(PAR_HBP_NOM))
                    && (r.hcnt < 12'(PAR_HBP_NOM + PAR_ACTIVE));
    end else begin
      in_line_act = (r.hcnt >= 12'(SER_HBP))
                    && (r.hcnt < 12'(SER_HBP + SER_ACTIVE));
    end
    if (hs_fall) begin
      // parallel and serial line length check
      // First line after reset has no opening sync, so it is not judged
      if (link.parallel_sel && r.vs_seen && r.hs_seen
          && ((r.hcnt < 12'(PAR_LINE_MIN - 1)) || (r.hcnt > 12'(PAR_LINE_MAX - 1)))) begin
        next_r.line_err = ~r.line_err;
      end
      if (!link.parallel_sel && r.vs_seen && r.hs_seen
          && (r.hcnt != 12'(SER_LINE - 1))) begin
        next_r.line_err = ~r.line_err;
      end
      next_r.hcnt = 12'h000;
      next_r.hs_seen = 1'b1;
      next_r.byte_ix = 2'h0;
      if (in_vact) begin
        next_r.act_line = r.act_line + 9'h001;
      end
      next_r.vcnt = r.vcnt + 9'h001;
      // count of shown lines ends the frame
      if (in_vact && (r.act_line == 9'(ACTIVE_LINES - 1))) begin
        next_r.frame_tgl = ~r.frame_tgl;
      end
    end else begin
      if (r.hcnt != 12'hFFF) begin
        next_r.hcnt = r.hcnt + 12'h001;
      end
      if (in_vact && in_line_act) begin
        if (link.parallel_sel) begin
          next_r.pix = {link.red_data_bus, link.green_data, link.blue_data};
          next_r.pix_v = 1'b1;
        end else begin
          case (r.byte_ix)
            2'h0: begin
              next_r.rg[15:8] = link.red_data_bus;
              next_r.byte_ix = 2'h1;
            end
            2'h1: begin
              next_r.rg[7:0] = link.red_data_bus;
              next_r.byte_ix = 2'h2;
            end
            2'h2: begin
              next_r.pix = {r.rg, link.red_data_bus};
              next_r.pix_v = 1'b1;
              next_r.byte_ix = 2'h0;
            end
            default: begin
              next_r.byte_ix = 2'h0;
            end
          endcase
        end
      end
    end
    if (vs_fall) begin
      next_r.vs_seen = 1'b1;
      next_r.vcnt = 9'h000;
      next_r.act_line = 9'h000;
    end
    // Events follow the counter so they stay on the line sync grid
    if (r.vs_seen && in_vact) begin
      next_r.src = (r.hcnt == DLY_SOURCE - 12'h001);
      next_r.gon = (r.hcnt == DLY_GATE_ON - 12'h001);
      next_r.goff = (r.hcnt == DLY_GATE_OFF - 12'h001);
      if (r.hcnt == DLY_COMMON_ELECTRODE_DRIVE - 12'h001) begin
        next_r.common_electrode_drive = ~r.common_electrode_drive;
      end
    end
  end

  always_ff @(posedge link.pixel_clock or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.hs_d <= 1'b1;
      r.vs_d <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  always_comb begin
    next_s = s;
    next_s.err_sync = {s.err_sync[0], r.line_err};
    next_s.done_sync = {s.done_sync[1:0], r.frame_tgl};
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_pixel = r.pix;
  assign o_pixel_valid = r.pix_v;
  assign o_line = r.act_line;
  assign o_source_load = r.src;
  assign o_gate_on = r.gon;
  assign o_gate_off = r.goff;
  assign o_common_electrode_drive = r.common_electrode_drive;
  // Toggle level, compare to last seen value in the bench if needed
  assign o_line_error = s.err_sync[1];
  assign o_frame_done = s.done_sync[2] ^ s.done_sync[1];
endmodule // rgb_in_panel
`default_nettype wire

// ==== design/rgb_in_pkg.sv ====
/*
  Shared constants for the RGB pixel input port: line and frame
  geometry for both input formats and the output event delays.
  Assumes both ends and the carrier interface import it.
*/
package rgb_in_pkg;
  // Parallel format
  localparam int unsigned PAR_LINE_MIN    = 520;
  localparam int unsigned PAR_LINE_NOM    = 525;
  localparam int unsigned PAR_LINE_MAX    = 800;
  localparam int unsigned PAR_ACTIVE      = 480;
  localparam int unsigned PAR_HBP_MIN     = 36;
  localparam int unsigned PAR_HBP_NOM     = 40;
  localparam int unsigned PAR_HBP_MAX     = 255;
  localparam int unsigned PAR_HFP_MIN     = 4;
  localparam int unsigned PAR_HFP_NOM     = 5;
  localparam int unsigned PAR_HFP_MAX     = 65;
  localparam real         PAR_CLK_MHZ_MIN = 5.0;
  localparam real         PAR_CLK_MHZ_NOM = 9.0;
  localparam real         PAR_CLK_MHZ_MAX = 12.0;
  // Serial format
  localparam int unsigned SER_LINE        = 1728;
  localparam int unsigned SER_ACTIVE      = 1440;
  localparam int unsigned SER_HBP         = 120;
  localparam int unsigned SER_HFP         = 168;
  localparam int unsigned SER_BYTES_PIX   = 3;
  localparam real         SER_CLK_MHZ_MIN = 24.0;
  localparam real         SER_CLK_MHZ_NOM = 27.0;
  localparam real         SER_CLK_MHZ_MAX = 30.0;
  // Vertical
  localparam int unsigned ACTIVE_LINES    = 272;
  localparam int unsigned VBP_MIN         = 3;
  localparam int unsigned VBP_NOM         = 8;
  localparam int unsigned VBP_MAX         = 31;
  localparam int unsigned VFP_MIN         = 2;
  localparam int unsigned VFP_NOM         = 8;
  localparam int unsigned VFP_MAX         = 97;
  localparam int unsigned FRAME_MIN       = 277;
  localparam int unsigned FRAME_NOM       = 288;
  localparam int unsigned FRAME_MAX       = 400;
  // Output events, pixel clocks after line sync
  localparam logic [11:0] DLY_SOURCE      = 12'h00D;
  localparam logic [11:0] DLY_GATE_ON     = 12'h01B;
  localparam logic [11:0] DLY_GATE_OFF    = 12'h003;
  localparam logic [11:0] DLY_COMMON_ELECTRODE_DRIVE        = 12'h00C;
  // Host-side times
  localparam real         CSB_TO_FRAME_US = 1.0;
  localparam real         RESET_MIN_US    = 10.0;
  localparam real         RESET_TYP_US    = 50.0;
  localparam real         MCLK_MHZ        = 125.0;
  localparam int unsigned CSB_GAP_CYC     = int'($ceil(CSB_TO_FRAME_US * MCLK_MHZ));
  localparam int unsigned RESET_CYC       = int'($ceil(RESET_MIN_US * MCLK_MHZ));
  localparam logic [4:0]  VSTART_RST      = 5'h08;
endpackage

// ==== sim/rgb_input_timing_properties.sv ====
/*
  Timing properties of the pixel link between host and panel ends.
  Assumes the bench connects link signals and panel outputs by name.
*/
`timescale 1ns/1ps
`default_nettype none
module rgb_input_timing_properties
  import rgb_in_pkg::*;
(
  input wire logic        i_mclk,
  input wire logic        i_arst_n,
  input wire logic        pixel_clock,
  input wire logic        line_sync_n,
  input wire logic        frame_sync_n,
  input wire logic        parallel_sel,
  input wire logic [7:0]  red_data_bus,
  input wire logic [7:0]  green_data,
  input wire logic [7:0]  blue_data,
  input wire logic        global_reset_n,
  input wire logic        config_chip_select_n,
  input wire logic [4:0]  i_vertical_start_delay,
  input wire logic [23:0] o_pixel,
  input wire logic        o_pixel_valid,
  input wire logic [8:0]  o_line,
  input wire logic        o_source_load,
  input wire logic        o_gate_on,
  input wire logic        o_gate_off,
  input wire logic        o_common_electrode_drive
);
  wire logic   prst_n = i_arst_n & global_reset_n;
  logic        seen;
  logic        fseen;
  logic        got_pix;
  logic [11:0] hlen;
  logic [8:0]  vline;
  logic [9:0]  npix;
  logic [10:0] csgap;
  logic [10:0] rstlen;

  // Seen flags keep pre-reset history out of the checks
  always_ff @(posedge pixel_clock or negedge prst_n) begin
    if (!prst_n) begin
      seen    <= 1'b0;
      fseen   <= 1'b0;
      got_pix <= 1'b0;
      hlen    <= 12'h000;
      vline   <= 9'h000;
      npix    <= 10'h000;
    end else begin
      seen  <= seen | $fell(line_sync_n);
      fseen <= fseen | $fell(frame_sync_n);
      hlen  <= $fell(line_sync_n) ? 12'h001 : hlen + 12'h001;
      npix  <= $fell(line_sync_n) ? 10'h000 : npix + {9'h000, o_pixel_valid};
      vline   <= $fell(frame_sync_n) ? 9'h000 : vline + {8'h00, $fell(line_sync_n)};
      got_pix <= !$fell(frame_sync_n) && (got_pix | o_pixel_valid);
    end
  end

  // Saturating counts so an idle link never wraps into a false pass
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      csgap  <= 11'h7FF;
      rstlen <= 11'h000;
    end else begin
      csgap  <= $rose(config_chip_select_n) ? 11'h001 : csgap + {10'h000, csgap != 11'h7FF};
      rstlen <= global_reset_n ? 11'h000 : rstlen + {10'h000, rstlen != 11'h7FF};
    end
  end

  sequence line_start;
    $fell(line_sync_n);
  endsequence
  sequence load_to_gate;
    o_source_load ##14 o_gate_on;
  endsequence

  chk_line_length: assert property (@(posedge pixel_clock) disable iff (!prst_n)
    line_start ##0 seen |-> (parallel_sel ? (hlen >= PAR_LINE_MIN && hlen <= PAR_LINE_MAX)
                                          : hlen == SER_LINE))
    else $error("line period out of range");
  chk_active_pixels: assert property (@(posedge pixel_clock) disable iff (!prst_n)
    line_start |-> (npix == 10'h000 || npix == PAR_ACTIVE))
    else $error("wrong pixel count in a line");
  chk_active_lines: assert property (@(posedge pixel_clock) disable iff (!prst_n)
    o_pixel_valid |-> o_line < ACTIVE_LINES)
    else $error("active line index too high");
  chk_first_line: assert property (@(posedge pixel_clock) disable iff (!prst_n)
    fseen && o_pixel_valid && !got_pix |-> vline == {4'h0, i_vertical_start_delay})
    else $error("first active line misplaced");
  chk_event_order: assert property (@(posedge pixel_clock) disable iff (!prst_n)
    seen && $changed(o_common_electrode_drive) |-> ##1 load_to_gate)
    else $error("source and gate events out of step");
  chk_gate_off: assert property (@(posedge pixel_clock) disable iff (!prst_n)
    o_gate_off && seen |-> hlen >= DLY_GATE_OFF && hlen <= DLY_GATE_OFF + 12'h002)
    else $error("gate off at wrong offset");
  chk_pixel_bytes: assert property (@(posedge pixel_clock) disable iff (!prst_n)
    o_pixel_valid |-> o_pixel === (parallel_sel
      ? {$past(red_data_bus), $past(green_data), $past(blue_data)}
      : {$past(red_data_bus, 3), $past(red_data_bus, 2), $past(red_data_bus)}))
    else $error("pixel not assembled from bus");
  chk_select_gap: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    $fell(frame_sync_n) |-> csgap >= CSB_GAP_CYC)
    else $error("frame sync too soon after chip select");
  // First edge after release may fall outside the count
  chk_reset_width: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    $rose(global_reset_n) |-> rstlen >= RESET_CYC - 1)
    else $error("link reset too short");
endmodule // rgb_input_timing_properties
`default_nettype wire

// ==== sim/test_rgb_input_timing.sv ====
/*
  Self-checking bench: host and panel ends joined by the pixel link.
  Assumes the host runs nominal geometry with the panel start delay at 8 in the parallel run, 3 or 4 in the serial run.
*/
`timescale 1ns/1ps
`default_nettype none
module test_rgb_input_timing;
  import rgb_in_pkg::*;
  logic        i_mclk;
  logic        i_arst_n;
  logic        i_parallel;
  logic        i_config_busy;
  logic [23:0] i_pixel;
  logic [4:0]  i_vertical_start_delay;
  logic        o_pixel_taken;
  logic        o_running;
  logic [23:0] o_pixel;
  logic        o_pixel_valid;
  logic        o_line_error;
  integer      seed;
  int          miscompares;
  int          n_checks;
  int          npix;
  int          n;
  logic        cmp_on;
  logic [23:0] exp_q[$];

  rgb_in_if u_link ();
  rgb_in_host u_rgb_in_host (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .link(u_link.host),
    .i_parallel(i_parallel), .i_config_busy(i_config_busy), .i_pixel(i_pixel),
    .o_pixel_taken(o_pixel_taken), .o_running(o_running));
  rgb_in_panel u_rgb_in_panel (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .link(u_link.panel),
    .i_vertical_start_delay(i_vertical_start_delay), .o_pixel(o_pixel),
    .o_pixel_valid(o_pixel_valid), .o_line(), .o_source_load(), .o_gate_on(),
    .o_gate_off(), .o_common_electrode_drive(), .o_line_error(o_line_error),
    .o_frame_done());
  rgb_input_timing_properties u_checker (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
    .pixel_clock(u_link.pixel_clock), .line_sync_n(u_link.line_sync_n),
    .frame_sync_n(u_link.frame_sync_n), .parallel_sel(u_link.parallel_sel),
    .red_data_bus(u_link.red_data_bus), .green_data(u_link.green_data),
    .blue_data(u_link.blue_data), .global_reset_n(u_link.global_reset_n),
    .config_chip_select_n(u_link.config_chip_select_n),
    .i_vertical_start_delay(i_vertical_start_delay), .o_pixel(o_pixel),
    .o_pixel_valid(o_pixel_valid), .o_line(u_rgb_in_panel.o_line),
    .o_source_load(u_rgb_in_panel.o_source_load), .o_gate_on(u_rgb_in_panel.o_gate_on),
    .o_gate_off(u_rgb_in_panel.o_gate_off),
    .o_common_electrode_drive(u_rgb_in_panel.o_common_electrode_drive));

  always #4 i_mclk = ~i_mclk;

  task automatic check_pix(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t pixel %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_num(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      miscompares++;
      $display("Error %0t count %0d expected %0d", $time, got, exp);
    end
  endtask

  function automatic int exp_line_len(input logic par);
    return par ? PAR_LINE_NOM : SER_LINE;
  endfunction

  task automatic print_verdict();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Chip select released after the link reset, so the sync gap is timed
  task automatic start_run(input logic par, input logic [4:0] dly);
    @(negedge i_mclk);
    i_arst_n = 1'b0;
    i_parallel = par;
    i_vertical_start_delay = dly;
    i_config_busy = 1'b1;
    repeat (12) @(negedge i_mclk);
    npix = 0;
    exp_q.delete();
    i_arst_n = 1'b1;
    repeat (1300) @(negedge i_mclk);
    i_config_busy = 1'b0;
  endtask

  // Pixel clocks between two line sync falls
  task automatic line_len(output int len);
    int   k;
    logic prev;
    k = 0;
    len = 0;
    prev = 1'b1;
    while (k < 2) begin
      @(posedge u_link.pixel_clock);
      if (k == 1) len++;
      if (prev && u_link.line_sync_n === 1'b0) k++;
      prev = u_link.line_sync_n;
    end
  endtask

  always @(negedge i_mclk) begin
    if (o_pixel_taken === 1'b1) begin
      exp_q.push_back(i_pixel);
      i_pixel <= 24'($random(seed));
    end
  end

  // Sampled mid-period, clear of the launching edge
  always @(negedge u_link.pixel_clock) begin
    if (o_pixel_valid === 1'b1) begin
      npix++;
      if (cmp_on) check_pix(o_pixel, exp_q.size() > 0 ? exp_q.pop_front() : 24'hXXXXXX);
    end
  end

  initial begin
    // Two runs take about 94k to 103k mclk cycles (serial start delay 3 or 4)
    #900_000;
    miscompares++;
    $display("Error %0t watchdog expired", $time);
    print_verdict();
  end

  initial begin
    i_mclk = 1'b0;
    i_arst_n = 1'b0;
    i_parallel = 1'b1;
    i_config_busy = 1'b1;
    i_pixel = 24'h000000;
    i_vertical_start_delay = VSTART_RST;
    seed = 32'hAA1EF02A;
    miscompares = 0;
    n_checks = 0;
    cmp_on = 1'b0;
    start_run(1'b1, VSTART_RST);
    check_num(o_running, 1);
    line_len(n);
    check_num(n, exp_line_len(1'b1));
    cmp_on = 1'b1;
    wait (npix == PAR_ACTIVE);
    @(negedge u_link.line_sync_n);
    check_num(npix, PAR_ACTIVE);
    check_pix({23'h000000, o_line_error}, 24'h000000);
    cmp_on = 1'b0;
    $display("test parallel done");
    n = 3 + $unsigned($random(seed)) % 2;
    start_run(1'b0, 5'(n));
    line_len(n);
    check_num(n, exp_line_len(1'b0));
    wait (npix == PAR_ACTIVE);
    @(negedge u_link.line_sync_n);
    check_num(npix * SER_BYTES_PIX, SER_ACTIVE);
    check_pix({23'h000000, o_line_error}, 24'h000000);
    $display("test serial done");
    print_verdict();
  end
endmodule // test_rgb_input_timing
`default_nettype wire
